/* design/cpm_top.sv */
// Camera PMU general I/O, privacy light and sensor clock control
// ==========================================================
// Summary of operation
// - General output level is control bit 0; bit 1 picks push-pull drive.
// - General output drives only while the first regulator is on.
// - Input-mode general I/O ORed with software bit enables second regulator.
// - I/O control bit 3 level, bit 4 direction, bit 5 drive type.
// - General I/O works only while the first regulator is on.
// - Privacy light is controlled by its enable pin alone.
// - Light enable low turns sink off; high runs the dimming PWM.
// - Oscillator runs when clock output enable or light enable is high.
// - Sensor clock output needs control bit 2; light pin alone never.
// - Clock enable with first regulator off: oscillator runs, pin silent.
// - Sensor clock starts after a further 131072 crystal cycles.
// - Dimming frequency select picks one of four PWM frequencies.
// - Ten-bit duty: eight PWM bits plus two dither bits.
// - Thermal event clears regulator enables; no automatic restart.
`timescale 1ns/1ps
module cpm_top #(
    parameter int STAB_CYCLES_P = cpm_pkg::STAB_CYCLES // Stabilisation wait
) (
    input  wire logic       clk,             // 200 MHz clock
    input  wire logic       srst,            // Sync reset, active high
    input  wire logic       reg_wr,          // Register write strobe
    input  wire logic       reg_rd,          // Register read strobe
    input  wire logic [7:0] reg_addr,        // Register address
    input  wire logic [7:0] reg_wdata,       // Write data
    output logic      [7:0] reg_rdata,       // Read data
    output logic            reg_rvalid,      // Read data valid
    input  wire logic       privacy_light_enable_pin, // Light enable pin
    input  wire logic       thermal_event,   // Thermal shutdown pulse
    input  wire logic       osc_stable,      // Oscillator is stable
    input  wire logic       gpio_in,         // General I/O pin level
    output logic            gpio_out,        // General I/O drive level
    output logic            gpio_oe,         // General I/O drive enable
    output logic            general_output_pin_out, // Output level
    output logic            general_output_pin_oe,  // Output enable
    output logic            sensor_clock_pin_out,   // Sensor clock level
    output logic            sensor_clock_pin_oe,    // Sensor clock enable
    output logic            first_regulator_en,     // First regulator on
    output logic            second_regulator_en,    // Second regulator on
    output logic            osc_enable,      // Crystal oscillator on
    output logic            isink_on         // LED current sink on
);
    import cpm_pkg::*;

    logic [7:0]             reg_ctrl_r;   // Regulator control
    logic [7:0]             gio_ctrl_r;   // General I/O control
    logic [7:0]             dim_osc_r;    // Dimming/oscillator control
    logic [DUTY_W-1:0]      duty_r;       // Duty cycle
    logic                   led_meta_r;   // Light pin sync stage 1
    logic                   led_sync_r;   // Light pin sync stage 2
    cpm_clk_state_t         clk_st_r;     // Sensor clock gate state
    cpm_clk_state_t         clk_st_nxt;
    logic [STAB_W-1:0]      stab_cnt_r;   // Stabilisation counter
    logic [OCLK_DIV_W-1:0]  oclk_div_r;   // Sensor clock divider
    logic                   pwm_level;
    logic                   clk_run;
    logic                   first_on;
    logic                   clock_output_enable_bit;

    assign first_on  = reg_ctrl_r[REG_FIRST_EN];
    assign clock_output_enable_bit = dim_osc_r[DIM_CLOCK_OUTPUT_ENABLE_BIT];
    // Count runs only while enabled and the oscillator is up
    assign clk_run   = clock_output_enable_bit && osc_enable && osc_stable;

    // ==========================================================
    // Register writes
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_ctrl_r <= REG_CTRL_RST;
        end else if (thermal_event) begin
            reg_ctrl_r <= REG_CTRL_RST;
        end else if (reg_wr && reg_addr == ADDR_REG_CTRL) begin
            reg_ctrl_r <= reg_wdata & REG_CTRL_MASK;
        end
    end

    // General I/O control; I/O level forced low without first regulator
    always_ff @(posedge clk) begin
        if (srst) begin
            gio_ctrl_r <= GIO_CTRL_RST;
        end else if (reg_wr && reg_addr == ADDR_GIO_CTRL) begin
            gio_ctrl_r <= reg_wdata & GIO_CTRL_MASK;
        end else if (!first_on) begin
            gio_ctrl_r[GIO_IO_LEVEL] <= 1'b0;
        end
    end

    // Dimming/oscillator control and duty
    always_ff @(posedge clk) begin
        if (srst) begin
            dim_osc_r <= DIM_OSC_RST;
            duty_r    <= DUTY_RST;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_DIM_OSC) begin
                dim_osc_r <= reg_wdata & DIM_OSC_MASK;
            end
            if (reg_addr == ADDR_DUTY_HI) begin
                duty_r[DUTY_W-1:DUTY_W-DUTY_HI_W] <= reg_wdata[DUTY_HI_W-1:0];
            end
            if (reg_addr == ADDR_DUTY_LO) begin
                duty_r[DUTY_W-DUTY_HI_W-1:0] <= reg_wdata;
            end
        end
    end

    // Register reads, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                unique case (reg_addr)
                    ADDR_REG_CTRL: reg_rdata <= reg_ctrl_r;
                    ADDR_GIO_CTRL: reg_rdata <= gio_ctrl_r;
                    ADDR_DIM_OSC:  reg_rdata <= dim_osc_r;
                    ADDR_DUTY_HI:  reg_rdata <= {6'h00, duty_r[9:8]};
                    ADDR_DUTY_LO:  reg_rdata <= duty_r[7:0];
                    ADDR_STATUS:   reg_rdata <= {3'h0, gpio_in,
                        second_regulator_en, led_sync_r,
                        clk_st_r == CPM_CLK_ACTIVE, osc_enable};
                    default:       reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ==========================================================
    // Regulator enables; input-mode I/O pin ORed with software bit
    always_ff @(posedge clk) begin
        if (srst) begin
            first_regulator_en  <= 1'b0;
            second_regulator_en <= 1'b0;
        end else begin
            first_regulator_en  <= first_on;
            second_regulator_en <= reg_ctrl_r[REG_SECOND_SW] ||
                (!gio_ctrl_r[GIO_IO_DIR] && first_on && gpio_in);
        end
    end

    // General output and general I/O pin drivers
    always_ff @(posedge clk) begin
        if (srst) begin
            general_output_pin_out <= 1'b0;
            general_output_pin_oe  <= 1'b0;
            gpio_out               <= 1'b0;
            gpio_oe                <= 1'b0;
        end else begin
            general_output_pin_out <= gio_ctrl_r[GIO_GPO_LEVEL];
            // Open drain drives only the low level
            general_output_pin_oe  <= first_on &&
                (gio_ctrl_r[GIO_GPO_PP] || !gio_ctrl_r[GIO_GPO_LEVEL]);
            gpio_out <= gio_ctrl_r[GIO_IO_LEVEL];
            gpio_oe  <= first_on && gio_ctrl_r[GIO_IO_DIR] &&
                (gio_ctrl_r[GIO_IO_PP] || !gio_ctrl_r[GIO_IO_LEVEL]);
        end
    end

    // ==========================================================
    // Light enable pin synchroniser
    always_ff @(posedge clk) begin
        if (srst) begin
            led_meta_r <= 1'b0;
            led_sync_r <= 1'b0;
        end else begin
            led_meta_r <= privacy_light_enable_pin;
            led_sync_r <= led_meta_r;
        end
    end

    cpm_pwm u_pwm (
        .clk      (clk),
        .srst     (srst),
        .enable   (led_sync_r),
        .freq_sel (dim_osc_r[DIM_FREQ_LSB +: 2]),
        .duty     (duty_r),
        .pwm_out  (pwm_level)
    );

    // Sink follows the PWM only while the pin is high
    always_ff @(posedge clk) begin
        if (srst) begin
            isink_on <= 1'b0;
        end else begin
            isink_on <= led_sync_r && pwm_level;
        end
    end

    // Oscillator on from the clock enable bit or the light pin
    always_ff @(posedge clk) begin
        if (srst) begin
            osc_enable <= 1'b0;
        end else begin
            osc_enable <= clock_output_enable_bit || led_sync_r;
        end
    end

    // ==========================================================
    // Sensor clock gate state
    always_comb begin
        clk_st_nxt = clk_st_r;
        unique case (clk_st_r)
            CPM_CLK_OFF: begin
                if (clk_run) clk_st_nxt = CPM_CLK_WAIT;
            end
            CPM_CLK_WAIT: begin
                if (!clk_run) begin
                    clk_st_nxt = CPM_CLK_OFF;
                end else if (stab_cnt_r == STAB_W'(STAB_CYCLES_P - 1)) begin
                    clk_st_nxt = CPM_CLK_ACTIVE;
                end
            end
            CPM_CLK_ACTIVE: begin
                if (!clk_run) clk_st_nxt = CPM_CLK_OFF;
            end
            default: clk_st_nxt = CPM_CLK_OFF;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            clk_st_r <= CPM_CLK_OFF;
        end else begin
            clk_st_r <= clk_st_nxt;
        end
    end

    // Stabilisation counter, cleared outside the wait state
    always_ff @(posedge clk) begin
        if (srst || !clk_run || clk_st_r != CPM_CLK_WAIT) begin
            stab_cnt_r <= '0;
        end else begin
            stab_cnt_r <= stab_cnt_r + STAB_W'(1);
        end
    end

    // Sensor clock divider and pin driver
    always_ff @(posedge clk) begin
        if (srst) begin
            oclk_div_r           <= '0;
            sensor_clock_pin_out <= 1'b0;
            sensor_clock_pin_oe  <= 1'b0;
        end else begin
            oclk_div_r          <= oclk_div_r + OCLK_DIV_W'(1);
            sensor_clock_pin_oe <= first_on;
            // Low unless gate is active and buffer powered
            sensor_clock_pin_out <= (clk_st_r == CPM_CLK_ACTIVE) && first_on
                && oclk_div_r[dim_osc_r[DIM_OSCF_LSB +: 2]];
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_gpo_oe_off: assert property (!first_on |=> !general_output_pin_oe)
        else $error("General output driven without regulator");

    chk_gpo_level: assert property (
        (first_on && gio_ctrl_r[GIO_GPO_PP]) |=>
        general_output_pin_oe &&
        general_output_pin_out == $past(gio_ctrl_r[GIO_GPO_LEVEL]))
        else $error("General output level wrong");

    chk_second_reg_or: assert property (
        (!gio_ctrl_r[GIO_IO_DIR] && first_on && gpio_in) |=>
        second_regulator_en)
        else $error("I/O pin failed to enable second regulator");

    chk_gpio_input: assert property (!gio_ctrl_r[GIO_IO_DIR] |=> !gpio_oe)
        else $error("General I/O driven in input mode");

    chk_gpio_power: assert property (!first_on |=> !gpio_oe)
        else $error("General I/O driven without regulator");

    chk_sink_off: assert property (!led_sync_r |=> !isink_on)
        else $error("Sink on with light enable low");

    chk_light_sync: assert property (
        $rose(privacy_light_enable_pin) ##1 privacy_light_enable_pin |=>
        led_sync_r)
        else $error("Light pin not synchronised in two cycles");

    chk_osc_enable: assert property (
        ##1 osc_enable == $past(clock_output_enable_bit || led_sync_r))
        else $error("Oscillator enable mismatch");

    chk_clk_gate: assert property (
        (clk_st_r != CPM_CLK_ACTIVE) |=> !sensor_clock_pin_out)
        else $error("Sensor clock before stabilisation");

    // First regulator must stay on through the middle cycle as well
    chk_clk_low: assert property (
        (!clock_output_enable_bit && first_on) ##1 (!clock_output_enable_bit && first_on) |=>
        sensor_clock_pin_oe && !sensor_clock_pin_out)
        else $error("Sensor clock pin not held low");

    chk_stab_count: assert property (
        (clk_st_r == CPM_CLK_WAIT && clk_st_nxt == CPM_CLK_ACTIVE) |->
        stab_cnt_r == STAB_W'(STAB_CYCLES_P - 1))
        else $error("Sensor clock active before full count");

    chk_stab_restart: assert property (!clk_run |=> stab_cnt_r == '0 &&
        clk_st_r == CPM_CLK_OFF)
        else $error("Stabilisation count not restarted");

    chk_thermal_clear: assert property (thermal_event |=>
        reg_ctrl_r[REG_FIRST_EN +: 2] == 2'h0 ##1 !first_regulator_en)
        else $error("Thermal event left regulators on");

endmodule

/* design/cpm_pkg.sv */
// Shared constants and types for the camera PMU I/O and clock control
package cpm_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_REG_CTRL  = 8'h00; // Regulator control
    localparam logic [7:0] ADDR_GIO_CTRL  = 8'h01; // General I/O control
    localparam logic [7:0] ADDR_DIM_OSC   = 8'h02; // Dimming/osc control
    localparam logic [7:0] ADDR_DUTY_HI   = 8'h03; // Duty bits 9:8
    localparam logic [7:0] ADDR_DUTY_LO   = 8'h04; // Duty bits 7:0
    localparam logic [7:0] ADDR_STATUS    = 8'h05; // Read-only status

    // ==========================================================
    // Field positions
    localparam int REG_FIRST_EN    = 0; // First regulator enable
    localparam int REG_SECOND_SW   = 1; // Second regulator sw enable
    localparam int GIO_GPO_LEVEL   = 0; // General output level
    localparam int GIO_GPO_PP      = 1; // General output push-pull
    localparam int GIO_IO_LEVEL    = 3; // General I/O output level
    localparam int GIO_IO_DIR      = 4; // General I/O is output
    localparam int GIO_IO_PP       = 5; // General I/O push-pull
    localparam int DIM_FREQ_LSB    = 0; // Dimming freq select, 2 bits
    localparam int DIM_CLOCK_OUTPUT_ENABLE_BIT   = 2; // Clock output enable bit
    localparam int DIM_OSCF_LSB    = 3; // Output clock freq select
    localparam int DUTY_W          = 10;
    localparam int DUTY_HI_W       = 2;

    // ==========================================================
    // Reset values and writable masks
    localparam logic [7:0] REG_CTRL_RST   = 8'h00;
    localparam logic [7:0] REG_CTRL_MASK  = 8'h03;
    localparam logic [7:0] GIO_CTRL_RST   = 8'h02; // Push-pull low, input
    localparam logic [7:0] GIO_CTRL_MASK  = 8'h3B;
    localparam logic [7:0] DIM_OSC_RST    = 8'h00;
    localparam logic [7:0] DIM_OSC_MASK   = 8'h1F;
    localparam logic [9:0] DUTY_RST       = 10'h000;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ          = 200;
    localparam int XTAL_MHZ         = 24;
    localparam int STAB_XTAL_CYCLES = 131072;
    // Wait rounded up to whole clk cycles
    localparam int STAB_CYCLES =
        (STAB_XTAL_CYCLES * CLK_MHZ + XTAL_MHZ - 1) / XTAL_MHZ;
    localparam int STAB_W           = 21;
    // PWM step rate is a quarter of the crystal rate
    localparam int PWM_BASE_DIV     = (CLK_MHZ * 4) / XTAL_MHZ;
    localparam int PWM_DIV_W        = 9;
    localparam int OCLK_DIV_W       = 4;

    // ==========================================================
    // Sensor clock gate states
    typedef enum logic [2:0] {
        CPM_CLK_OFF    = 3'b001,
        CPM_CLK_WAIT   = 3'b010,
        CPM_CLK_ACTIVE = 3'b100
    } cpm_clk_state_t;

endpackage

/* design/cpm_pwm.sv */
// Dimming PWM generator with 8-bit period and 2-bit dither
`timescale 1ns/1ps
module cpm_pwm (
    input  wire logic                         clk,      // System clock
    input  wire logic                         srst,     // Sync reset
    input  wire logic                         enable,   // Run PWM
    input  wire logic [1:0]                   freq_sel, // Frequency select
    input  wire logic [cpm_pkg::DUTY_W-1:0]   duty,     // Duty value
    output logic                              pwm_out   // PWM level
);
    import cpm_pkg::*;

    logic [PWM_DIV_W-1:0] pre_r;    // Prescaler
    logic [7:0]           step_r;   // Position in period
    logic [1:0]           frame_r;  // Dither frame
    logic [PWM_DIV_W-1:0] pre_top;
    logic [8:0]           on_len;

    // Prescale grows by powers of two with freq_sel
    assign pre_top = PWM_DIV_W'((PWM_BASE_DIV << freq_sel) - 1);
    // Dither adds one step in duty[1:0] of every four periods
    assign on_len = {1'b0, duty[9:2]} + 9'((frame_r < duty[1:0]) ? 1 : 0);

    // Counters, cleared while disabled so a start is clean
    always_ff @(posedge clk) begin
        if (srst || !enable) begin
            pre_r   <= '0;
            step_r  <= '0;
            frame_r <= '0;
        end else if (pre_r >= pre_top) begin
            pre_r  <= '0;
            step_r <= step_r + 8'h01;
            if (step_r == 8'hFF) begin
                frame_r <= frame_r + 2'h1;
            end
        end else begin
            pre_r <= pre_r + PWM_DIV_W'(1);
        end
    end

    // Output level
    always_ff @(posedge clk) begin
        if (srst || !enable) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= ({1'b0, step_r} < on_len);
        end
    end

    chk_pwm_zero_duty: assert property (@(posedge clk) disable iff (srst)
        (duty == '0) [*2] |-> !pwm_out)
        else $error("PWM high with zero duty");

endmodule

/* sim/cpm_host.sv */
// Host model: register strobes and the privacy light pin
`timescale 1ns/1ps
module cpm_host (
    input  wire logic       clk,        // System clock
    output logic            reg_wr,     // Write strobe
    output logic            reg_rd,     // Read strobe
    output logic      [7:0] reg_addr,   // Register address
    output logic      [7:0] reg_wdata,  // Write data
    input  wire logic [7:0] reg_rdata,  // Read data
    input  wire logic       reg_rvalid, // Read data valid
    output logic            light_pin   // Privacy light enable pin
);
    // ==========================================================
    // Idle levels from time zero
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        light_pin = 1'b0;
    end
    // One write, held until the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= dat;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~dat; // Stale data must not look valid
    endtask
    // One read; data and valid taken one cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] dat,
                      output logic vld);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        dat = reg_rdata;
        vld = reg_rvalid;
    endtask
    // Light pin level change at a clock edge
    task automatic light(input logic lvl);
        @(posedge clk);
        light_pin <= lvl;
    endtask
endmodule

/* sim/tb_camera_pmu_io_clock_control.sv */
// Self-checking bench for the camera PMU control block
`timescale 1ns/1ps
module tb_camera_pmu_io_clock_control;
    import cpm_pkg::*;
    localparam int STAB = 16;
    typedef struct packed {
        logic [7:0] rc, gio, dim;
        logic       light, ext;
        logic [7:0] exp;
    } cpm_row_t;
    logic       clk = 1'b0, srst = 1'b1, therm, stable;
    logic       ext, wr, rd, light, rvalid, g_out, g_oe;
    logic       o_out, o_oe, s_out, s_oe, first, second, osc, isink, v;
    logic [7:0] addr, wdata, rdata, d;
    int         errors = 0, total_checks = 0, n, p;
    cpm_row_t   rows [8];
    wire        gpio_w = g_oe ? g_out : ext; // Wire level at the pin
    wire  [7:0] outs = {o_oe, o_oe & o_out, g_oe, g_oe & g_out,
                        first, second, osc, s_oe};

    cpm_host cpm_host_inst (.clk(clk), .reg_wr(wr), .reg_rd(rd),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .light_pin(light));
    cpm_top #(.STAB_CYCLES_P(STAB)) cpm_top_inst (.clk(clk),
        .srst(srst), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .privacy_light_enable_pin(light), .thermal_event(therm),
        .osc_stable(stable), .gpio_in(gpio_w), .gpio_out(g_out),
        .gpio_oe(g_oe), .general_output_pin_out(o_out),
        .general_output_pin_oe(o_oe), .sensor_clock_pin_out(s_out),
        .sensor_clock_pin_oe(s_oe), .first_regulator_en(first),
        .second_regulator_en(second), .osc_enable(osc),
        .isink_on(isink));

    // ==========================================================
    // Clock, compare helpers and closing
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        cpm_host_inst.rd(a, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, e);
    endtask
    // Cycles with sensor clock (sel 0) or sink (sel 1) not low
    task automatic busy(input int k, input bit sel, output int c);
        c = 0;
        repeat (k) begin
            tick(1);
            c += sel ? (isink !== 1'b0) : (s_out !== 1'b0);
        end
    endtask
    task automatic wait_clk(output int c);
        c = 0;
        while (s_out !== 1'b1 && c < 200) begin
            tick(1);
            c++;
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rows = '{'{8'h00, 8'h3B, 8'h04, 1'b0, 1'b1, 8'h02},
                 '{8'h01, 8'h02, 8'h00, 1'b0, 1'b1, 8'h8D},
                 '{8'h01, 8'h01, 8'h00, 1'b0, 1'b0, 8'h09},
                 '{8'h01, 8'h00, 8'h00, 1'b1, 1'b0, 8'h8B},
                 '{8'h03, 8'h38, 8'h00, 1'b0, 1'b0, 8'hBD},
                 '{8'h01, 8'h1B, 8'h00, 1'b0, 1'b1, 8'hC9},
                 '{8'h01, 8'h10, 8'h04, 1'b0, 1'b1, 8'hAB},
                 '{8'h02, 8'h03, 8'h00, 1'b0, 1'b0, 8'h04}};
        // Idle levels of the pins that the bench drives itself
        therm  = 1'b0;
        stable = 1'b0;
        ext    = 1'b0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[k]) begin
            cpm_host_inst.wr(ADDR_REG_CTRL, rows[k].rc);
            cpm_host_inst.wr(ADDR_GIO_CTRL, rows[k].gio);
            cpm_host_inst.wr(ADDR_DIM_OSC, rows[k].dim);
            cpm_host_inst.light(rows[k].light);
            ext <= rows[k].ext;
            tick(6);
            chk(outs, rows[k].exp);
        end
        $display("test pin rows done");
        // Unwritable bits read 0, unmapped place ignores writes
        cpm_host_inst.wr(ADDR_REG_CTRL, 8'h01);
        cpm_host_inst.wr(ADDR_GIO_CTRL, 8'hFF);
        rdchk(ADDR_GIO_CTRL, 8'h3B);
        cpm_host_inst.wr(8'h07, 8'h55);
        rdchk(8'h07, 8'h00);
        $display("test register access done");
        // Sensor clock: light alone, start count, restart
        cpm_host_inst.wr(ADDR_GIO_CTRL, 8'h02);
        stable <= 1'b1;
        cpm_host_inst.wr(ADDR_DIM_OSC, 8'h18);
        cpm_host_inst.light(1'b1);
        busy(40, 1'b0, n);
        chk_cnt(n, 0, 0);
        chk({7'h00, s_oe}, 8'h01);
        cpm_host_inst.light(1'b0);
        cpm_host_inst.wr(ADDR_DIM_OSC, 8'h1C);
        wait_clk(n);
        // Two cycles to start the count, up to eight for the divider phase
        chk_cnt(n, STAB + 2, STAB + 10);
        cpm_host_inst.wr(ADDR_DIM_OSC, 8'h18);
        busy(20, 1'b0, n);
        chk_cnt(n, 0, 3);
        cpm_host_inst.wr(ADDR_DIM_OSC, 8'h1C);
        tick(8);
        @(posedge clk);
        stable <= 1'b0;
        @(posedge clk);
        stable <= 1'b1;
        wait_clk(n);
        chk_cnt(n, STAB + 2, STAB + 10);
        $display("test sensor clock done");
        // Dimming: one step on-time at each frequency code
        cpm_host_inst.wr(ADDR_DUTY_HI, 8'h00);
        cpm_host_inst.wr(ADDR_DUTY_LO, 8'h04);
        for (int s = 0; s < 4; s++) begin
            cpm_host_inst.wr(ADDR_DIM_OSC, s[7:0]);
            cpm_host_inst.light(1'b1);
            n = 0;
            while (isink !== 1'b1 && n < 100) begin
                tick(1);
                n++;
            end
            n = 0;
            while (isink === 1'b1 && n < 1000) begin
                tick(1);
                n++;
            end
            p = PWM_BASE_DIV << s; // One step at this frequency code
            chk_cnt(n, p - 1, p + 1);
            cpm_host_inst.light(1'b0);
            tick(5);
        end
        // Full duty with pin low, zero duty with pin high: sink stays off
        cpm_host_inst.wr(ADDR_DUTY_HI, 8'h03);
        cpm_host_inst.wr(ADDR_DUTY_LO, 8'hFF);
        busy(100, 1'b1, n);
        chk_cnt(n, 0, 0);
        cpm_host_inst.wr(ADDR_DUTY_HI, 8'h00);
        cpm_host_inst.wr(ADDR_DUTY_LO, 8'h00);
        cpm_host_inst.light(1'b1);
        busy(300, 1'b1, n);
        chk_cnt(n, 0, 0);
        cpm_host_inst.light(1'b0);
        $display("test dimming done");
        // Thermal event clears both enables with no restart
        cpm_host_inst.wr(ADDR_REG_CTRL, 8'h03);
        @(posedge clk);
        therm <= 1'b1;
        @(posedge clk);
        therm <= 1'b0;
        tick(20);
        chk({6'h00, first, second}, 8'h00);
        rdchk(ADDR_REG_CTRL, 8'h00);
        $display("test thermal done");
        // Reset in mid-run restores every register
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        tick(1);
        chk(outs, 8'h00);
        for (int a = 0; a < 8; a++) begin
            rdchk(a[7:0], (a == 1) ? GIO_CTRL_RST : 8'h00);
        end
        $display("test reset done");
        test_done;
    end

    // Watchdog well beyond the expected run length
    initial begin
        #200000;
        errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        test_done;
    end
endmodule
